// ### hw/spl_preset_loader.sv
`timescale 1ns/1ns

module spl_preset_loader #(
  parameter int DATA_W   = 32,
  parameter int NUM_CHAN = 4,
  parameter int NUM_PROF = 4
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Avalon-MM slave
  input  wire logic [13:0]                         avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [31:0]                         avs_writedata,
  input  wire logic [3:0]                          avs_byteenable,
  output logic      [31:0]                         avs_readdata,
  output logic                                     avs_waitrequest,
  // Configuration source pin
  input  wire logic                                config_source_pin,
  // Translation memory read port
  output logic      [spl_pkg::ROM_ADDR_W-1:0]      rom_addr,
  input  wire logic [DATA_W-1:0]                   rom_data,
  // Output-side translation values
  output logic      [DATA_W-1:0]                   free_run_tuning_word,
  output logic      [DATA_W-1:0]                   output_feedback_divider,
  output logic      [DATA_W-1:0]                   analog_loop_divider,
  output logic      [NUM_CHAN-1:0][DATA_W-1:0]     channel_output_dividers,
  // Input-side translation values, one entry per reference profile
  output logic      [NUM_PROF-1:0][DATA_W-1:0]     reference_period,
  output logic      [NUM_PROF-1:0][DATA_W-1:0]     input_divider,
  output logic      [NUM_PROF-1:0][DATA_W-1:0]     integer_feedback_value,
  output logic      [NUM_PROF-1:0][DATA_W-1:0]     fraction_numerator,
  output logic      [NUM_PROF-1:0][DATA_W-1:0]     fraction_modulus,
  // System clock PLL settings
  output logic                                     sysclk_doubler_on,
  output logic                                     sysclk_use_crystal,
  output logic      [15:0]                         sysclk_ref_khz,
  output logic      [4:0]                          sysclk_feedback_div,
  // Status
  output logic                                     soft_active,
  output logic                                     loader_busy
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam logic [2:0] OUT_LAST =
    3'(int'(spl_pkg::OUT_CH0) + NUM_CHAN - 1);
  localparam logic [2:0] IN_LAST  = spl_pkg::IN_MOD;

  typedef struct packed {
    logic [2:0]                          pin_sync;
    logic                                pin_level;
    logic                                pin_start;
    logic                                started;
    logic [2:0]                          start_cnt;
    logic                                soft_enable;
    logic [7:0]                          freq_select;
    logic [1:0]                          sys_preset;
    spl_pkg::spl_state_type              state;
    logic [2:0]                          word;
    logic                                cap_valid;
    logic                                cap_table;
    logic [2:0]                          cap_word;
    logic [spl_pkg::ROM_ADDR_W-1:0]      rom_addr;
    logic                                waitrequest;
    logic [31:0]                         readdata;
    logic [DATA_W-1:0]                   tuning_word;
    logic [DATA_W-1:0]                   out_fb_div;
    logic [DATA_W-1:0]                   loop_div;
    logic [NUM_CHAN-1:0][DATA_W-1:0]     chan_div;
    logic [NUM_PROF-1:0][DATA_W-1:0]     ref_period;
    logic [NUM_PROF-1:0][DATA_W-1:0]     in_div;
    logic [NUM_PROF-1:0][DATA_W-1:0]     int_fb;
    logic [NUM_PROF-1:0][DATA_W-1:0]     frac_num;
    logic [NUM_PROF-1:0][DATA_W-1:0]     frac_mod;
    logic                                sys_doubler;
    logic                                sys_xtal;
    logic [15:0]                         sys_ref_khz;
    logic [4:0]                          sys_fb_div;
    logic                                active;
    logic                                walking;
  } spl_core_type;

  spl_core_type core;
  spl_core_type next_core;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [13:0] addr,
                                    input logic [11:0] idx);
    return addr[13:2] == idx;
  endfunction : addr_hit

  logic pin_allows;
  logic allowed;
  logic busy;
  logic wr_commit;
  logic wr_lane0;

  // Soft registers act only when the pin was low at startup and still is.
  assign pin_allows = core.started & ~core.pin_start & ~core.pin_level;
  assign allowed    = core.soft_enable & pin_allows;
  assign busy       = (core.state != spl_pkg::ST_IDLE) | core.cap_valid;
  assign wr_commit  = avs_write & ~core.waitrequest;
  assign wr_lane0   = wr_commit & avs_byteenable[0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic start_load;
    start_load = 1'b0;
    next_core  = core;

    // Pin synchroniser; only the last two stages are compared.
    next_core.pin_sync = {core.pin_sync[1:0], config_source_pin};
    if (core.pin_sync[1] == core.pin_sync[2])
    begin
      next_core.pin_level = core.pin_sync[2];
    end

    // The pin is taken once after reset, when the filter has settled.
    if (!core.started)
    begin
      if (core.start_cnt == spl_pkg::START_SETTLE)
      begin
        next_core.started   = 1'b1;
        next_core.pin_start = core.pin_level;
      end
      else
      begin
        next_core.start_cnt = core.start_cnt + 3'h1;
      end
    end

    // Bus: one wait cycle, accesses held off while a load runs.
    next_core.waitrequest = 1'b1;
    if ((avs_read | avs_write) && core.waitrequest && !busy)
    begin
      next_core.waitrequest = 1'b0;
      next_core.readdata    = 32'h0000_0000;
      if (addr_hit(avs_address, spl_pkg::IDX_SOFT_ENABLE))
      begin
        next_core.readdata[spl_pkg::ENABLE_BIT] = core.soft_enable;
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_FREQ_SELECT))
      begin
        next_core.readdata[7:0] = core.freq_select;
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_SYSCLK_PRESET))
      begin
        next_core.readdata[1:0] = core.sys_preset;
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_LOADER_STATUS))
      begin
        next_core.readdata[spl_pkg::STAT_ACTIVE_BIT] = allowed;
        next_core.readdata[spl_pkg::STAT_BUSY_BIT]   = busy;
        next_core.readdata[spl_pkg::STAT_PIN_BIT]    = core.pin_start;
      end
    end

    // Register writes take effect on the edge after the wait, which ends the cycle with waitrequest low.
    if (wr_lane0)
    begin
      if (addr_hit(avs_address, spl_pkg::IDX_SOFT_ENABLE))
      begin
        next_core.soft_enable = avs_writedata[spl_pkg::ENABLE_BIT];
        if (avs_writedata[spl_pkg::ENABLE_BIT] && !core.soft_enable
            && pin_allows)
        begin
          start_load = 1'b1;
        end
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_FREQ_SELECT))
      begin
        next_core.freq_select = avs_writedata[7:0];
        start_load            = allowed;
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_SYSCLK_PRESET))
      begin
        next_core.sys_preset = avs_writedata[1:0];
      end
      else if (addr_hit(avs_address, spl_pkg::IDX_SYSCLK_APPLY))
      begin
        // The preset is stored on write but used only on apply.
        if (avs_writedata[spl_pkg::APPLY_BIT] && allowed)
        begin
          next_core.sys_doubler = spl_pkg::SYS_DOUBLER[core.sys_preset];
          next_core.sys_xtal    = spl_pkg::SYS_XTAL[core.sys_preset];
          next_core.sys_ref_khz = spl_pkg::SYS_REF_KHZ[core.sys_preset];
          next_core.sys_fb_div  = spl_pkg::SYS_FB_DIV[core.sys_preset];
        end
      end
    end

    // Memory walk: address issued now, word captured on the next edge.
    next_core.cap_valid = 1'b0;
    unique case (core.state)
      spl_pkg::ST_IDLE:
      begin
        if (start_load)
        begin
          next_core.state = spl_pkg::ST_LOAD_OUT;
          next_core.word  = 3'h0;
        end
      end
      spl_pkg::ST_LOAD_OUT:
      begin
        next_core.rom_addr  = {spl_pkg::TABLE_OUT,
          core.freq_select[spl_pkg::OUT_IDX_LSB +: 4], core.word};
        next_core.cap_valid = 1'b1;
        next_core.cap_table = spl_pkg::TABLE_OUT;
        next_core.cap_word  = core.word;
        next_core.word      = core.word + 3'h1;
        if (core.word == OUT_LAST)
        begin
          next_core.state = spl_pkg::ST_LOAD_IN;
          next_core.word  = 3'h0;
        end
      end
      spl_pkg::ST_LOAD_IN:
      begin
        next_core.rom_addr  = {spl_pkg::TABLE_IN,
          core.freq_select[spl_pkg::IN_IDX_LSB +: 4], core.word};
        next_core.cap_valid = 1'b1;
        next_core.cap_table = spl_pkg::TABLE_IN;
        next_core.cap_word  = core.word;
        next_core.word      = core.word + 3'h1;
        if (core.word == IN_LAST)
        begin
          next_core.state = spl_pkg::ST_IDLE;
          next_core.word  = 3'h0;
        end
      end
      default:
      begin
        next_core.state = spl_pkg::ST_IDLE;
      end
    endcase

    // Captured words land in their target registers.
    if (core.cap_valid && core.cap_table == spl_pkg::TABLE_OUT)
    begin
      if (core.cap_word == spl_pkg::OUT_TW)
      begin
        next_core.tuning_word = rom_data;
      end
      if (core.cap_word == spl_pkg::OUT_FB)
      begin
        next_core.out_fb_div = rom_data;
      end
      if (core.cap_word == spl_pkg::OUT_LOOP)
      begin
        next_core.loop_div = rom_data;
      end
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        if (core.cap_word == 3'(int'(spl_pkg::OUT_CH0) + c))
        begin
          next_core.chan_div[c] = rom_data;
        end
      end
    end
    if (core.cap_valid && core.cap_table == spl_pkg::TABLE_IN)
    begin
      // One memory word feeds every profile alike.
      for (int p = 0; p < NUM_PROF; p++)
      begin
        if (core.cap_word == spl_pkg::IN_PERIOD)
        begin
          next_core.ref_period[p] = rom_data;
        end
        if (core.cap_word == spl_pkg::IN_RDIV)
        begin
          next_core.in_div[p] = rom_data;
        end
        if (core.cap_word == spl_pkg::IN_INT)
        begin
          next_core.int_fb[p] = rom_data;
        end
        if (core.cap_word == spl_pkg::IN_FRAC)
        begin
          next_core.frac_num[p] = rom_data;
        end
        if (core.cap_word == spl_pkg::IN_MOD)
        begin
          next_core.frac_mod[p] = rom_data;
        end
      end
    end

    // Status flops follow the next state, so they move with what they report.
    next_core.active  = next_core.soft_enable & next_core.started
                        & ~next_core.pin_start & ~next_core.pin_level;
    next_core.walking = next_core.state != spl_pkg::ST_IDLE;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core             <= '0;
      core.pin_sync    <= 3'h7;
      core.pin_level   <= 1'b1;
      core.pin_start   <= 1'b1;
      core.waitrequest <= 1'b1;
      core.freq_select <= spl_pkg::SELECT_RESET;
      core.sys_preset  <= spl_pkg::PRESET_RESET;
      core.state       <= spl_pkg::ST_IDLE;
    end
    else
    begin
      core <= next_core;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign avs_readdata            = core.readdata;
  assign avs_waitrequest         = core.waitrequest;
  assign rom_addr                = core.rom_addr;
  assign free_run_tuning_word    = core.tuning_word;
  assign output_feedback_divider = core.out_fb_div;
  assign analog_loop_divider     = core.loop_div;
  assign channel_output_dividers = core.chan_div;
  assign reference_period        = core.ref_period;
  assign input_divider           = core.in_div;
  assign integer_feedback_value  = core.int_fb;
  assign fraction_numerator      = core.frac_num;
  assign fraction_modulus        = core.frac_mod;
  assign sysclk_doubler_on       = core.sys_doubler;
  assign sysclk_use_crystal      = core.sys_xtal;
  assign sysclk_ref_khz          = core.sys_ref_khz;
  assign sysclk_feedback_div     = core.sys_fb_div;
  // A pin that rises after startup drops the active flag four edges later, once the synchroniser passes it.
  assign soft_active             = core.active;
  assign loader_busy             = core.walking;

endmodule : spl_preset_loader

// ### pkg/spl_pkg.sv
package spl_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [11:0] IDX_SOFT_ENABLE   = 12'hc00;
  localparam logic [11:0] IDX_FREQ_SELECT   = 12'hc01;
  localparam logic [11:0] IDX_SYSCLK_PRESET = 12'hc02;
  localparam logic [11:0] IDX_SYSCLK_APPLY  = 12'hc07;
  localparam logic [11:0] IDX_LOADER_STATUS = 12'hc08;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          ENABLE_BIT      = 0;
  localparam int          APPLY_BIT       = 0;
  localparam int          OUT_IDX_LSB     = 4;
  localparam int          IN_IDX_LSB      = 0;
  localparam int          STAT_ACTIVE_BIT = 0;
  localparam int          STAT_BUSY_BIT   = 1;
  localparam int          STAT_PIN_BIT    = 2;
  localparam logic [7:0]  SELECT_RESET    = 8'h00;
  localparam logic [1:0]  PRESET_RESET    = 2'h0;

  // ----------------------------------------------------------------------
  // Translation memory layout: {table, index, word}
  // ----------------------------------------------------------------------
  localparam int          ROM_ADDR_W = 8;
  localparam logic        TABLE_OUT  = 1'b0;
  localparam logic        TABLE_IN   = 1'b1;
  localparam logic [2:0]  OUT_TW     = 3'h0;
  localparam logic [2:0]  OUT_FB     = 3'h1;
  localparam logic [2:0]  OUT_LOOP   = 3'h2;
  localparam logic [2:0]  OUT_CH0    = 3'h3;
  localparam logic [2:0]  IN_PERIOD  = 3'h0;
  localparam logic [2:0]  IN_RDIV    = 3'h1;
  localparam logic [2:0]  IN_INT     = 3'h2;
  localparam logic [2:0]  IN_FRAC    = 3'h3;
  localparam logic [2:0]  IN_MOD     = 3'h4;

  // ----------------------------------------------------------------------
  // System clock presets, indexed by the two-bit code
  // ----------------------------------------------------------------------
  localparam logic [3:0]        SYS_DOUBLER = 4'h3;
  localparam logic [3:0]        SYS_XTAL    = 4'h3;
  localparam logic [3:0][15:0]  SYS_REF_KHZ = {16'hc000, 16'h6000,
                                               16'hc000, 16'h6000};
  localparam logic [3:0][4:0]   SYS_FB_DIV  = {5'h08, 5'h10, 5'h08, 5'h08};

  // ----------------------------------------------------------------------
  // Timing: edges after reset release before the pin level is trusted
  // ----------------------------------------------------------------------
  localparam logic [2:0]  START_SETTLE = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_LOAD_OUT = 2'b01,
    ST_LOAD_IN  = 2'b10
  } spl_state_type;

endpackage : spl_pkg

// ### test/spl_preset_loader_bench.sv
`timescale 1ns/1ns

module spl_preset_loader_bench;
  logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0;
  logic [13:0] addr = 14'h0000;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic wait_n;
  logic [7:0] raddr;
  logic [31:0] rom;
  logic [31:0] tw, fb, lp;
  logic [3:0][31:0] ch, per, rdv, ifb, frn, fmd;
  logic dbl, xtal, act, busy;
  logic [15:0] khz;
  logic [4:0] sfb;
  int num_errors = 0, comparisons = 0;

  // --------------------------------------------------------------------
  // Clock, design and translation memory
  // --------------------------------------------------------------------
  always #10 clk = ~clk;
  // Each memory word carries its own address, so a wrong fetch shows.
  assign rom = 32'h5a5a_5a00 | {24'h00_0000, raddr};

  spl_preset_loader dut (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wait_n),
    .config_source_pin(pin), .rom_addr(raddr), .rom_data(rom),
    .free_run_tuning_word(tw), .output_feedback_divider(fb),
    .analog_loop_divider(lp), .channel_output_dividers(ch),
    .reference_period(per), .input_divider(rdv),
    .integer_feedback_value(ifb), .fraction_numerator(frn),
    .fraction_modulus(fmd), .sysclk_doubler_on(dbl),
    .sysclk_use_crystal(xtal), .sysclk_ref_khz(khz),
    .sysclk_feedback_div(sfb), .soft_active(act), .loader_busy(busy)
  );

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %s: %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task bus(input logic w, input logic [11:0] idx, input logic [7:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_n !== 1'b0 && n < 100);
    if (n >= 100)
      check(1'b1, 1'b0, "bus timeout");
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task wreg(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg

  task rcheck(input logic [11:0] idx, input logic [7:0] e, string s);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, {24'h00_0000, e}, s);
  endtask : rcheck

  function automatic logic [31:0] rom_exp(logic t, logic [3:0] i,
                                         logic [2:0] w);
    return 32'h5a5a_5a00 | {24'h00_0000, t, i, w};
  endfunction : rom_exp

  task check_load(input logic [7:0] s);
    check(tw, rom_exp(1'b0, s[7:4], 3'h0), "tuning");
    check(fb, rom_exp(1'b0, s[7:4], 3'h1), "fb div");
    check(lp, rom_exp(1'b0, s[7:4], 3'h2), "loop div");
    for (int c = 0; c < 4; c++)
    begin
      check(ch[c], rom_exp(1'b0, s[7:4], 3'(3 + c)), "chan");
      check(per[c], rom_exp(1'b1, s[3:0], 3'h0), "period");
      check(rdv[c], rom_exp(1'b1, s[3:0], 3'h1), "in div");
      check(ifb[c], rom_exp(1'b1, s[3:0], 3'h2), "int fb");
      check(frn[c], rom_exp(1'b1, s[3:0], 3'h3), "frac");
      check(fmd[c], rom_exp(1'b1, s[3:0], 3'h4), "mod");
    end
  endtask : check_load

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task test_disabled;
    rcheck(12'hc00, 8'h00, "enable reset");
    rcheck(12'hc05, 8'h00, "unmapped");
    wreg(12'hc01, 8'h37);
    wreg(12'hc02, 8'h01);
    wreg(12'hc07, 8'h01);
    rcheck(12'hc01, 8'h37, "select");
    check(act, 1'b0, "active");
    check(tw, 32'h0000_0000, "tuning held");
    check(per[3], 32'h0000_0000, "period held");
    check(khz, 16'h0000, "sys held");
    $display("test_disabled done");
  endtask : test_disabled

  task test_load;
    wreg(12'hc00, 8'h01);
    rcheck(12'hc00, 8'h01, "enable");
    check(act, 1'b1, "active");
    check_load(8'h37);
    rcheck(12'hc08, 8'h01, "status");
    wreg(12'hc01, 8'hf0);
    wreg(12'hc01, 8'h0f);
    rcheck(12'hc01, 8'h0f, "select");
    check_load(8'h0f);
    $display("test_load done");
  endtask : test_load

  task test_presets;
    logic [15:0] k[4];
    logic [4:0] f[4];
    logic [15:0] prev;
    k = '{16'h6000, 16'hc000, 16'h6000, 16'hc000};
    f = '{5'h08, 5'h08, 5'h10, 5'h08};
    prev = khz;
    for (int c = 0; c < 4; c++)
    begin
      wreg(12'hc02, 8'(c));
      rcheck(12'hc02, 8'(c), "preset");
      check(khz, prev, "before apply");
      wreg(12'hc07, 8'h01);
      rcheck(12'hc07, 8'h00, "apply reads 0");
      check(khz, k[c], "ref");
      check(sfb, f[c], "fb");
      check(dbl, c < 2, "doubler");
      check(xtal, c < 2, "crystal");
      prev = k[c];
    end
    $display("test_presets done");
  endtask : test_presets

  task test_pin_high;
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    check(act, 1'b0, "active");
    wreg(12'hc01, 8'h5c);
    wreg(12'hc02, 8'h02);
    wreg(12'hc07, 8'h01);
    rcheck(12'hc01, 8'h5c, "select");
    check_load(8'h0f);
    check(sfb, 5'h08, "sys held");
    check(khz, 16'hc000, "ref held");
    rcheck(12'hc08, 8'h00, "status");
    $display("test_pin_high done");
  endtask : test_pin_high

  // --------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // --------------------------------------------------------------------
  task end_of_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Leave the pin synchroniser time to capture the startup level.
    repeat (8) @(posedge clk);
    test_disabled();
    test_load();
    test_presets();
    test_pin_high();
    end_of_test();
  end
endmodule : spl_preset_loader_bench

// ### test/spl_preset_loader_props.sv
`timescale 1ns/1ns

module spl_preset_loader_props #(
  parameter int DATA_W   = 32,
  parameter int NUM_CHAN = 4,
  parameter int NUM_PROF = 4
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register bus
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  // Pin and results
  input wire logic              config_source_pin,
  input wire logic [DATA_W-1:0] free_run_tuning_word,
  input wire logic              sysclk_doubler_on,
  input wire logic              sysclk_use_crystal,
  input wire logic [15:0]       sysclk_ref_khz,
  input wire logic [4:0]        sysclk_feedback_div,
  input wire logic              soft_active,
  input wire logic              loader_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_no_ack_idle: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("acknowledge without a request");
  a_ack_bounded: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:16] !avs_waitrequest) else $error("bus access never answered");
  a_busy_bounded: assert property ($rose(loader_busy) |-> ##[1:16] !loader_busy)
    else $error("translation load too long");
  a_load_needs_soft: assert property ($rose(loader_busy) |-> soft_active)
    else $error("load started while section not active");
  a_pin_blocks_soft: assert property (config_source_pin[*6] |-> !soft_active)
    else $error("soft section active with pin high");
  a_idle_word_hold: assert property (!soft_active && !loader_busy
    |=> $stable(free_run_tuning_word)) else $error("word moved");
  a_sys_hold: assert property (!soft_active |=> $stable(sysclk_ref_khz)
    && $stable(sysclk_feedback_div)) else $error("system preset moved");
  a_doubler_pair: assert property (sysclk_doubler_on |-> sysclk_use_crystal
    && sysclk_feedback_div == 5'h08) else $error("bad doubler preset");
  a_fast_ref_div: assert property (sysclk_ref_khz == 16'hc000
    |-> sysclk_feedback_div == 5'h08) else $error("bad 49 MHz preset");

  c_load: cover property ($rose(loader_busy));
  c_soft: cover property ($rose(soft_active));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule : spl_preset_loader_props

bind spl_preset_loader spl_preset_loader_props #(
  .DATA_W(DATA_W), .NUM_CHAN(NUM_CHAN), .NUM_PROF(NUM_PROF)
) u_props (
  .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .config_source_pin(config_source_pin),
  .free_run_tuning_word(free_run_tuning_word),
  .sysclk_doubler_on(sysclk_doubler_on),
  .sysclk_use_crystal(sysclk_use_crystal), .sysclk_ref_khz(sysclk_ref_khz),
  .sysclk_feedback_div(sysclk_feedback_div), .soft_active(soft_active),
  .loader_busy(loader_busy)
);
